// ==== hw/sfp_pkg.sv ====
// Shared constants and types for the slave FIFO port and its external master.
// Assumes a 250 MHz reference clock at both ends.
package sfp_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int NUM_FIFOS  = 4;
	localparam int SEL_W      = 2;
	localparam int DATA_W     = 16;
	localparam int FIFO_DEPTH = 16;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int REF_CLK_PERIOD_NS = 4;
	localparam int IFACE_PERIOD_NS   = 64;
	// Half period of the interface clock in reference cycles
	localparam int IFACE_HALF_CYCLES = IFACE_PERIOD_NS / (2 * REF_CLK_PERIOD_NS);
	localparam int DIV_W             = 8;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic RST_CS_N  = 1'b1;
	localparam logic RST_OE_N  = 1'b1;
	localparam logic RST_READY = 1'b1;

	// ****************************************************************
	// Commands and states
	// ****************************************************************
	typedef enum logic [1:0] {
		SFP_OP_READ   = 2'b00,
		SFP_OP_WRITE  = 2'b01,
		SFP_OP_COMMIT = 2'b10
	} sfp_op_t;

	typedef enum logic [1:0] {
		SFP_ST_IDLE  = 2'b00,
		SFP_ST_SETUP = 2'b01,
		SFP_ST_WAIT  = 2'b10,
		SFP_ST_XFER  = 2'b11
	} sfp_state_t;

endpackage

// ==== hw/sfp_link_if.sv ====
// Pins between the slave FIFO port and the external master.
// The shared data bus level is resolved here from both output enables.
`timescale 1ns/10ps
interface sfp_link_if #(
	parameter int W = sfp_pkg::DATA_W
);
	logic                      interface_clock;
	logic [sfp_pkg::SEL_W-1:0] fifo_select;
	logic                      port_chip_select_n;
	logic                      port_read_strobe;
	logic                      port_write_strobe;
	logic                      port_output_enable;
	logic                      packet_commit_strobe;
	logic [W-1:0]              host_data;
	logic                      host_data_oe_n;
	logic [W-1:0]              dev_data;
	logic                      dev_data_oe_n;
	logic                      full_flag;
	logic                      empty_flag;
	logic [W-1:0]              data_bus;

	// Device wins if both drive; undriven bus reads zero
	assign data_bus = !dev_data_oe_n ? dev_data : (!host_data_oe_n ? host_data : '0);

	modport dev (
		input  interface_clock, fifo_select, port_chip_select_n, port_read_strobe,
		input  port_write_strobe, port_output_enable, packet_commit_strobe, data_bus,
		output dev_data, dev_data_oe_n, full_flag, empty_flag
	);

	modport host (
		output interface_clock, fifo_select, port_chip_select_n, port_read_strobe,
		output port_write_strobe, port_output_enable, packet_commit_strobe,
		output host_data, host_data_oe_n,
		input  data_bus, full_flag, empty_flag
	);
endinterface

// ==== hw/sfp_slave_port.sv ====
// Device end: four FIFOs reached by an external master over a synchronous port.
// Assumes every link pin is asynchronous to ref_clk_in; the master makes the
// interface clock and changes its outputs away from the rising edge.
`timescale 1ns/10ps
module sfp_slave_port #(
	parameter int W     = sfp_pkg::DATA_W,
	parameter int DEPTH = sfp_pkg::FIFO_DEPTH,
	parameter int AW    = $clog2(DEPTH)
) (
	// Clock and reset
	input  wire logic                      ref_clk_in,
	input  wire logic                      rst_in,
	// Link to the external master
	sfp_link_if.dev                        link,
	// Loading words for the master to read
	input  wire logic                      load_valid_in,
	input  wire logic [sfp_pkg::SEL_W-1:0] load_sel_in,
	input  wire logic [W-1:0]              load_data_in,
	output logic                           load_ack_out,
	// Draining words the master wrote
	input  wire logic                      unload_valid_in,
	input  wire logic [sfp_pkg::SEL_W-1:0] unload_sel_in,
	output logic                           unload_ack_out,
	output logic [W-1:0]                   unload_data_out,
	// Packet commit report
	output logic                           packet_done_out,
	output logic [sfp_pkg::SEL_W-1:0]      packet_fifo_out,
	output logic [AW:0]                    packet_words_out
);
	localparam int NF = sfp_pkg::NUM_FIFOS;
	localparam int PW = 6 + sfp_pkg::SEL_W + W;
	localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);

	// ****************************************************************
	// Pin synchroniser
	// ****************************************************************
	logic [PW-1:0]             pin_meta;
	logic [PW-1:0]             pin_sync;
	logic                      clk_prev;
	logic                      s_clk;
	logic                      s_cs_n;
	logic                      s_rd;
	logic                      s_wr;
	logic                      s_oe;
	logic                      s_pkt;
	logic [sfp_pkg::SEL_W-1:0] s_sel;
	logic [W-1:0]              s_data;
	logic                      link_edge;

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= {link.interface_clock, link.port_chip_select_n, link.port_read_strobe,
			             link.port_write_strobe, link.port_output_enable,
			             link.packet_commit_strobe, link.fifo_select, link.data_bus};
			pin_sync <= pin_meta;
		end
	end

	assign {s_clk, s_cs_n, s_rd, s_wr, s_oe, s_pkt, s_sel, s_data} = pin_sync;

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			clk_prev <= 1'b0;
		end else begin
			clk_prev <= s_clk;
		end
	end

	assign link_edge = s_clk & ~clk_prev;

	// ****************************************************************
	// Access decode
	// ****************************************************************
	logic [W-1:0] mem [NF][DEPTH];
	logic [AW-1:0] wptr [NF];
	logic [AW-1:0] rptr [NF];
	logic [AW:0]   count [NF];
	logic [AW:0]   pend [NF];
	logic [NF-1:0] full;
	logic [NF-1:0] empty;
	logic [NF-1:0] push;
	logic [NF-1:0] pop;
	logic          rd_go;
	logic          wr_go;
	logic          commit_go;
	logic          load_go;
	logic          unload_go;

	always_comb begin
		for (int f = 0; f < NF; f++) begin
			full[f]  = (count[f] == FULL_LEVEL);
			empty[f] = (count[f] == '0);
		end
	end

	assign rd_go = link_edge & ~s_cs_n & s_rd & ~empty[s_sel];
	assign wr_go = link_edge & ~s_cs_n & s_wr & ~full[s_sel];
	assign commit_go = link_edge & s_pkt;
	// Master side has priority over user side on the same FIFO
	assign load_go = load_valid_in & ~full[load_sel_in] & ~(wr_go & (s_sel == load_sel_in));
	assign unload_go = unload_valid_in & ~empty[unload_sel_in]
	                   & ~(rd_go & (s_sel == unload_sel_in));

	always_comb begin
		for (int f = 0; f < NF; f++) begin
			push[f] = (wr_go & (s_sel == f[sfp_pkg::SEL_W-1:0]))
			        | (load_go & (load_sel_in == f[sfp_pkg::SEL_W-1:0]));
			pop[f]  = (rd_go & (s_sel == f[sfp_pkg::SEL_W-1:0]))
			        | (unload_go & (unload_sel_in == f[sfp_pkg::SEL_W-1:0]));
		end
	end

	// ****************************************************************
	// Storage and pointers
	// ****************************************************************
	// store data bus word
	always_ff @(posedge ref_clk_in) begin
		if (wr_go) begin
			mem[s_sel][wptr[s_sel]] <= s_data;
		end
		// Load never shares a FIFO with a link write, so both may store
		if (load_go) begin
			mem[load_sel_in][wptr[load_sel_in]] <= load_data_in;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		for (int f = 0; f < NF; f++) begin
			if (rst_in) begin
				wptr[f]  <= '0;
				rptr[f]  <= '0;
				count[f] <= '0;
			end else begin
				if (push[f]) begin
					wptr[f] <= wptr[f] + 1'b1;
				end
				if (pop[f]) begin
					rptr[f] <= rptr[f] + 1'b1;
				end
				if (push[f] && !pop[f]) begin
					count[f] <= count[f] + 1'b1;
				end else if (pop[f] && !push[f]) begin
					count[f] <= count[f] - 1'b1;
				end
			end
		end
	end

	// ****************************************************************
	// Short packet commit
	// ****************************************************************
	always_ff @(posedge ref_clk_in) begin
		for (int f = 0; f < NF; f++) begin
			if (rst_in) begin
				pend[f] <= '0;
			end else if (commit_go && s_sel == f[sfp_pkg::SEL_W-1:0]) begin
				pend[f] <= '0;
			end else if (wr_go && s_sel == f[sfp_pkg::SEL_W-1:0]) begin
				pend[f] <= pend[f] + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			packet_done_out  <= 1'b0;
			packet_fifo_out  <= '0;
			packet_words_out <= '0;
		end else begin
			packet_done_out <= commit_go;
			if (commit_go) begin
				packet_fifo_out  <= s_sel;
				packet_words_out <= pend[s_sel] + (AW+1)'(wr_go);
			end
		end
	end

	// ****************************************************************
	// User side answers
	// ****************************************************************
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			load_ack_out    <= 1'b0;
			unload_ack_out  <= 1'b0;
			unload_data_out <= '0;
		end else begin
			load_ack_out   <= load_go;
			unload_ack_out <= unload_go;
			if (unload_go) begin
				unload_data_out <= mem[unload_sel_in][rptr[unload_sel_in]];
			end
		end
	end

	// ****************************************************************
	// Link outputs
	// ****************************************************************
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			link.dev_data      <= '0;
			link.dev_data_oe_n <= sfp_pkg::RST_OE_N;
			link.full_flag     <= 1'b0;
			link.empty_flag    <= 1'b1;
		end else begin
			link.dev_data      <= mem[s_sel][rptr[s_sel]];
			link.dev_data_oe_n <= ~s_oe;
			link.full_flag     <= full[s_sel];
			link.empty_flag    <= empty[s_sel];
		end
	end

endmodule // sfp_slave_port

// ==== hw/sfp_ext_master.sv ====
// External master end: makes the interface clock and performs single accesses.
// Assumes the device answers on the link pins within half an interface period.
`timescale 1ns/10ps
module sfp_ext_master #(
	parameter int W    = sfp_pkg::DATA_W,
	parameter int HALF = sfp_pkg::IFACE_HALF_CYCLES
) (
	// Clock and reset
	input  wire logic                      ref_clk_in,
	input  wire logic                      rst_in,
	// Link to the device
	sfp_link_if.host                       link,
	// Command port
	input  wire logic                      cmd_valid_in,
	input  wire sfp_pkg::sfp_op_t          cmd_op_in,
	input  wire logic [sfp_pkg::SEL_W-1:0] cmd_sel_in,
	input  wire logic [W-1:0]              cmd_data_in,
	output logic                           cmd_ready_out,
	// Read answers and flags
	output logic                           rsp_valid_out,
	output logic [W-1:0]                   rsp_data_out,
	output logic                           full_out,
	output logic                           empty_out
);
	// ****************************************************************
	// Interface clock divider
	// ****************************************************************
	logic [sfp_pkg::DIV_W-1:0] div_cnt;
	logic                      tick;
	logic                      fall;
	logic                      rise;

	assign tick = (div_cnt == sfp_pkg::DIV_W'(HALF - 1));
	assign fall = tick & link.interface_clock;
	assign rise = tick & ~link.interface_clock;

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			div_cnt              <= '0;
			link.interface_clock <= 1'b0;
		end else if (tick) begin
			div_cnt              <= '0;
			link.interface_clock <= ~link.interface_clock;
		end else begin
			div_cnt <= div_cnt + 1'b1;
		end
	end

	// ****************************************************************
	// Input synchroniser
	// ****************************************************************
	logic [W+1:0] in_meta;
	logic [W+1:0] in_sync;

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			in_meta <= '0;
			in_sync <= '0;
		end else begin
			in_meta <= {link.full_flag, link.empty_flag, link.data_bus};
			in_sync <= in_meta;
		end
	end

	// ****************************************************************
	// Access sequencer
	// ****************************************************************
	sfp_pkg::sfp_state_t state;
	sfp_pkg::sfp_op_t    op;
	logic                accept;

	assign accept = cmd_valid_in & cmd_ready_out;

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			state <= sfp_pkg::SFP_ST_IDLE;
		end else begin
			case (state)
				sfp_pkg::SFP_ST_IDLE: begin
					if (accept) begin
						state <= sfp_pkg::SFP_ST_SETUP;
					end
				end
				sfp_pkg::SFP_ST_SETUP: begin
					if (fall) begin
						state <= sfp_pkg::SFP_ST_WAIT;
					end
				end
				// one full cycle of stable select
				sfp_pkg::SFP_ST_WAIT: begin
					if (fall) begin
						state <= sfp_pkg::SFP_ST_XFER;
					end
				end
				sfp_pkg::SFP_ST_XFER: begin
					if (fall) begin
						state <= sfp_pkg::SFP_ST_IDLE;
					end
				end
				default: begin
					state <= sfp_pkg::SFP_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			op                      <= sfp_pkg::SFP_OP_READ;
			cmd_ready_out           <= sfp_pkg::RST_READY;
			link.fifo_select        <= '0;
			link.host_data          <= '0;
			link.port_chip_select_n <= sfp_pkg::RST_CS_N;
		end else if (accept) begin
			op                      <= cmd_op_in;
			cmd_ready_out           <= 1'b0;
			link.fifo_select        <= cmd_sel_in;
			link.host_data          <= cmd_data_in;
			link.port_chip_select_n <= 1'b0;
		end else if (state == sfp_pkg::SFP_ST_XFER && fall) begin
			// select held until strobe is gone
			cmd_ready_out           <= 1'b1;
			link.port_chip_select_n <= 1'b1;
		end
	end

	// Strobes change on falling edges only
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			link.port_read_strobe     <= 1'b0;
			link.port_output_enable   <= 1'b0;
			link.port_write_strobe    <= 1'b0;
			link.packet_commit_strobe <= 1'b0;
			link.host_data_oe_n       <= sfp_pkg::RST_OE_N;
		end else if (state == sfp_pkg::SFP_ST_WAIT && fall) begin
			link.port_read_strobe     <= (op == sfp_pkg::SFP_OP_READ);
			link.port_output_enable   <= (op == sfp_pkg::SFP_OP_READ);
			link.port_write_strobe    <= (op == sfp_pkg::SFP_OP_WRITE);
			// commit never on a write edge
			link.packet_commit_strobe <= (op == sfp_pkg::SFP_OP_COMMIT);
			link.host_data_oe_n       <= (op != sfp_pkg::SFP_OP_WRITE);
		end else if (state == sfp_pkg::SFP_ST_XFER && fall) begin
			link.port_read_strobe     <= 1'b0;
			link.port_output_enable   <= 1'b0;
			link.port_write_strobe    <= 1'b0;
			link.packet_commit_strobe <= 1'b0;
			link.host_data_oe_n       <= 1'b1;
		end
	end

	// ****************************************************************
	// Answers
	// ****************************************************************
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			rsp_valid_out <= 1'b0;
			rsp_data_out  <= '0;
			full_out      <= 1'b0;
			empty_out     <= 1'b1;
		end else begin
			rsp_valid_out <= rise & (state == sfp_pkg::SFP_ST_XFER) & (op == sfp_pkg::SFP_OP_READ);
			if (rise && state == sfp_pkg::SFP_ST_XFER && op == sfp_pkg::SFP_OP_READ) begin
				rsp_data_out <= in_sync[W-1:0];
			end
			full_out  <= in_sync[W+1];
			empty_out <= in_sync[W];
		end
	end

endmodule // sfp_ext_master

// ==== verif/sfp_link_asserts.sv ====
// Checker on the link pins between the slave port and the external master.
// Assumes both ends share ref_clk_in and rst_in; instantiated beside the interface.
`timescale 1ns/10ps
module sfp_link_asserts #(
	parameter int HALF = 8
) (
	// Clock and reset
	input wire logic                      ref_clk_in,
	input wire logic                      rst_in,
	// Link pins
	input wire logic                      interface_clock,
	input wire logic [sfp_pkg::SEL_W-1:0] fifo_select,
	input wire logic                      port_chip_select_n,
	input wire logic                      port_read_strobe,
	input wire logic                      port_write_strobe,
	input wire logic                      port_output_enable,
	input wire logic                      packet_commit_strobe,
	input wire logic                      host_data_oe_n,
	input wire logic                      dev_data_oe_n,
	input wire logic                      full_flag,
	input wire logic                      empty_flag
);
	// ****************************************************************
	// Select age counter
	// ****************************************************************
	logic [sfp_pkg::SEL_W-1:0] sel_prev;
	logic [7:0]                sel_age;

	always_ff @(posedge ref_clk_in) begin
		sel_prev <= fifo_select;
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in || fifo_select != sel_prev) begin
			sel_age <= 8'h00;
		end else if (sel_age != 8'hff) begin
			sel_age <= sel_age + 8'h01;
		end
	end

	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	chk_oe_releases_bus: assert property (!port_output_enable [*6] |-> dev_data_oe_n)
		else $error("device drives bus without output enable");
	chk_oe_drives_bus: assert property (port_output_enable [*6] |-> !dev_data_oe_n)
		else $error("device idle on bus under output enable");
	chk_read_cs_first: assert property ($rose(port_read_strobe) |->
		!port_chip_select_n && $past(port_chip_select_n) == 1'b0)
		else $error("read strobe before chip select");
	chk_write_cs_with: assert property ($rose(port_write_strobe) |-> !port_chip_select_n)
		else $error("write strobe without chip select");
	chk_sel_setup_held: assert property (
		$rose(port_read_strobe || port_write_strobe) |-> sel_age >= HALF)
		else $error("select changed too close to strobe");
	chk_write_held_edge: assert property ($rose(port_write_strobe) |->
		port_write_strobe throughout ##[1:16] $rose(interface_clock))
		else $error("write strobe dropped before link edge");
	chk_write_data_on: assert property ($rose(interface_clock) && port_write_strobe |->
		!host_data_oe_n && $past(host_data_oe_n) == 1'b0)
		else $error("write edge without master data");
	chk_write_sets_flag: assert property ($rose(interface_clock) &&
		!port_chip_select_n && port_write_strobe |-> ##[2:10] !empty_flag)
		else $error("empty flag stuck after write");
	chk_commit_sel_held: assert property (
		packet_commit_strobe && $past(packet_commit_strobe) |-> $stable(fifo_select))
		else $error("select moved during commit");
	chk_flags_exclusive: assert property (!(full_flag && empty_flag))
		else $error("full and empty together");

	cov_write: cover property ($rose(interface_clock) && port_write_strobe);
	cov_read: cover property ($rose(interface_clock) && port_read_strobe);
	cov_commit: cover property ($rose(packet_commit_strobe));
endmodule // sfp_link_asserts

// ==== verif/tb_slave_fifo_sync_port.sv ====
// Testbench: master and port on link_a, bench-driven master on link_b.
// Assumes the package, interface and both ends are compiled first.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("ERROR %s expected %h seen %h", nm, e, g); \
	end \
end
module tb_slave_fifo_sync_port;
	localparam int W = sfp_pkg::DATA_W;
	localparam int S = sfp_pkg::SEL_W;
	localparam int AW = $clog2(sfp_pkg::FIFO_DEPTH);
	logic             ref_clk_in = 1'h0;
	logic             rst_in = 1'h1;
	logic             cmd_valid = 1'h0;
	sfp_pkg::sfp_op_t cmd_op = sfp_pkg::SFP_OP_READ;
	logic [S-1:0]     cmd_sel = '0;
	logic [W-1:0]     cmd_data = '0;
	logic             cmd_ready;
	logic             rsp_valid;
	logic [W-1:0]     rsp_data;
	logic             full_out;
	logic             empty_out;
	logic             ld_v = 1'h0;
	logic             ul_v = 1'h0;
	logic [S-1:0]     ld_sel = '0;
	logic [S-1:0]     ul_sel = '0;
	logic [W-1:0]     ld_data = '0;
	logic [1:0]       ld_ack;
	logic [1:0]       ul_ack;
	logic [1:0]       pk_done;
	logic [W-1:0]     ul_data [2];
	logic [S-1:0]     pk_fifo [2];
	logic [AW:0]      pk_words [2];
	int               n_errors = 0;
	int               cmp_count = 0;
	int               n_rsp = 0;
	int               n_pkt [2] = '{0, 0};

	sfp_link_if link_a ();
	sfp_link_if link_b ();

	// ****************************************************************
	// Ends under test
	// ****************************************************************
	sfp_slave_port u_sfp_slave_port (.ref_clk_in, .rst_in, .link(link_a),
		.load_valid_in(ld_v), .load_sel_in(ld_sel), .load_data_in(ld_data),
		.load_ack_out(ld_ack[0]), .unload_valid_in(ul_v), .unload_sel_in(ul_sel),
		.unload_ack_out(ul_ack[0]), .unload_data_out(ul_data[0]),
		.packet_done_out(pk_done[0]), .packet_fifo_out(pk_fifo[0]),
		.packet_words_out(pk_words[0]));
	sfp_slave_port u_sfp_slave_port_b (.ref_clk_in, .rst_in, .link(link_b),
		.load_valid_in(ld_v), .load_sel_in(ld_sel), .load_data_in(ld_data),
		.load_ack_out(ld_ack[1]), .unload_valid_in(ul_v), .unload_sel_in(ul_sel),
		.unload_ack_out(ul_ack[1]), .unload_data_out(ul_data[1]),
		.packet_done_out(pk_done[1]), .packet_fifo_out(pk_fifo[1]),
		.packet_words_out(pk_words[1]));
	sfp_ext_master u_sfp_ext_master (.ref_clk_in, .rst_in, .link(link_a),
		.cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op), .cmd_sel_in(cmd_sel),
		.cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready), .rsp_valid_out(rsp_valid),
		.rsp_data_out(rsp_data), .full_out(full_out), .empty_out(empty_out));
	sfp_link_asserts #(.HALF(sfp_pkg::IFACE_HALF_CYCLES)) u_sfp_link_asserts (
		.ref_clk_in, .rst_in, .interface_clock(link_a.interface_clock),
		.fifo_select(link_a.fifo_select), .port_chip_select_n(link_a.port_chip_select_n),
		.port_read_strobe(link_a.port_read_strobe),
		.port_write_strobe(link_a.port_write_strobe),
		.port_output_enable(link_a.port_output_enable),
		.packet_commit_strobe(link_a.packet_commit_strobe),
		.host_data_oe_n(link_a.host_data_oe_n), .dev_data_oe_n(link_a.dev_data_oe_n),
		.full_flag(link_a.full_flag), .empty_flag(link_a.empty_flag));

	// ****************************************************************
	// Clocks, counters and tasks
	// ****************************************************************
	always #2 ref_clk_in = ~ref_clk_in;

	// Link_b clock toggled on reference edges
	initial begin
		link_b.interface_clock = 1'h0;
		forever begin
			repeat (sfp_pkg::IFACE_HALF_CYCLES) @(posedge ref_clk_in);
			link_b.interface_clock <= ~link_b.interface_clock;
		end
	end

	always @(posedge ref_clk_in) begin
		for (int i = 0; i < 2; i++) begin
			if (pk_done[i] === 1'h1)
				n_pkt[i]++;
		end
		if (rsp_valid === 1'h1)
			n_rsp++;
	end

	task automatic summarize();
		$display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic load(input logic [S-1:0] s, input logic [W-1:0] v, input int d);
		int i;
		@(posedge ref_clk_in);
		ld_v <= 1'h1;
		ld_sel <= s;
		ld_data <= v;
		@(posedge ref_clk_in);
		ld_v <= 1'h0;
		#1;
		for (i = 0; i < 4 && ld_ack[d] !== 1'h1; i++) begin
			@(posedge ref_clk_in);
			#1;
		end
		`CHK("load ack", 1'h1, ld_ack[d])
	endtask

	task automatic unload(input logic [S-1:0] s, input int d, input logic ok,
		input logic [W-1:0] e);
		int i;
		@(posedge ref_clk_in);
		ul_v <= 1'h1;
		ul_sel <= s;
		@(posedge ref_clk_in);
		ul_v <= 1'h0;
		#1;
		for (i = 0; i < 4 && ul_ack[d] !== 1'h1; i++) begin
			@(posedge ref_clk_in);
			#1;
		end
		`CHK("unload ack", ok, ul_ack[d])
		if (ok)
			`CHK("unload data", e, ul_data[d])
	endtask

	task automatic mcmd(input sfp_pkg::sfp_op_t op, input logic [S-1:0] s,
		input logic [W-1:0] v);
		int i;
		@(posedge ref_clk_in);
		cmd_valid <= 1'h1;
		cmd_op <= op;
		cmd_sel <= s;
		cmd_data <= v;
		@(posedge ref_clk_in);
		cmd_valid <= 1'h0;
		#1;
		for (i = 0; i < 400 && cmd_ready !== 1'h1; i++) begin
			@(posedge ref_clk_in);
			#1;
		end
		repeat (8) @(posedge ref_clk_in);
		#1;
		if (i >= 400) begin
			n_errors++;
			summarize();
		end
	endtask

	// Link_b pins change on the falling link edge
	task automatic bedge(input logic cs_n, rd, wr, oe, pe, input logic [W-1:0] v);
		@(negedge link_b.interface_clock);
		link_b.port_chip_select_n <= cs_n;
		link_b.port_read_strobe <= rd;
		link_b.port_write_strobe <= wr;
		link_b.port_output_enable <= oe;
		link_b.packet_commit_strobe <= pe;
		link_b.host_data <= v;
		link_b.host_data_oe_n <= !wr;
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		link_b.fifo_select = '0;
		link_b.port_chip_select_n = 1'h1;
		link_b.port_read_strobe = 1'h0;
		link_b.port_write_strobe = 1'h0;
		link_b.port_output_enable = 1'h0;
		link_b.packet_commit_strobe = 1'h0;
		link_b.host_data = '0;
		link_b.host_data_oe_n = 1'h1;
		repeat (10) @(posedge ref_clk_in);
		rst_in <= 1'h0;
		repeat (4) @(posedge ref_clk_in);
		for (int k = 0; k < 4; k++)
			load(2'h0, 16'h0b00 + 16'(k), 1);
		bedge(1'h0, 1'h0, 1'h0, 1'h0, 1'h0, '0);
		bedge(1'h0, 1'h1, 1'h0, 1'h0, 1'h0, '0);
		bedge(1'h1, 1'h1, 1'h0, 1'h1, 1'h0, '0);
		`CHK("bus released", 1'h1, link_b.dev_data_oe_n)
		bedge(1'h0, 1'h1, 1'h0, 1'h1, 1'h0, '0);
		`CHK("prefetch word", 16'h0b01, link_b.data_bus)
		bedge(1'h0, 1'h1, 1'h0, 1'h1, 1'h0, '0);
		`CHK("read advance", 16'h0b02, link_b.data_bus)
		bedge(1'h0, 1'h1, 1'h0, 1'h1, 1'h0, '0);
		`CHK("burst next", 16'h0b03, link_b.data_bus)
		bedge(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, '0);
		`CHK("burst empties", 1'h1, link_b.empty_flag)
		$display("Test link_b read done");
		bedge(1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 16'h0bad);
		for (int k = 0; k < 4; k++)
			bedge(1'h0, 1'h0, 1'h1, 1'h0, 1'(k == 3), 16'h0c00 + 16'(k));
		bedge(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, '0);
		bedge(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, '0);
		`CHK("packet count b", 1, n_pkt[1])
		`CHK("packet words b", 5'h04, pk_words[1])
		`CHK("packet fifo b", 2'h0, pk_fifo[1])
		link_b.fifo_select <= 2'h1;
		bedge(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, '0);
		`CHK("flag other fifo", 1'h1, link_b.empty_flag)
		link_b.fifo_select <= 2'h0;
		bedge(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, '0);
		`CHK("flag back", 1'h0, link_b.empty_flag)
		for (int k = 0; k < 4; k++)
			unload(2'h0, 1, 1'h1, 16'h0c00 + 16'(k));
		unload(2'h0, 1, 1'h0, '0);
		$display("Test link_b write done");
		load(2'h1, 16'h1111, 0);
		load(2'h1, 16'h2222, 0);
		mcmd(sfp_pkg::SFP_OP_READ, 2'h1, '0);
		`CHK("first read", 16'h1111, rsp_data)
		mcmd(sfp_pkg::SFP_OP_READ, 2'h1, '0);
		`CHK("second read", 16'h2222, rsp_data)
		mcmd(sfp_pkg::SFP_OP_READ, 2'h1, '0);
		`CHK("empty flag", 1'h1, empty_out)
		load(2'h1, 16'h3333, 0);
		mcmd(sfp_pkg::SFP_OP_READ, 2'h1, '0);
		`CHK("read after empty", 16'h3333, rsp_data)
		`CHK("read answers", 4, n_rsp)
		$display("Test master read done");
		for (int k = 0; k < 3; k++)
			mcmd(sfp_pkg::SFP_OP_WRITE, 2'h2, 16'h00a0 + 16'(k));
		mcmd(sfp_pkg::SFP_OP_COMMIT, 2'h2, '0);
		`CHK("packet count", 1, n_pkt[0])
		`CHK("packet words", 5'h03, pk_words[0])
		`CHK("packet fifo", 2'h2, pk_fifo[0])
		for (int k = 0; k < 3; k++)
			unload(2'h2, 0, 1'h1, 16'h00a0 + 16'(k));
		unload(2'h2, 0, 1'h0, '0);
		$display("Test master write done");
		for (int k = 0; k < 16; k++)
			load(2'h3, 16'h0300 + 16'(k), 0);
		mcmd(sfp_pkg::SFP_OP_WRITE, 2'h3, 16'hdead);
		`CHK("full flag", 1'h1, full_out)
		for (int k = 0; k < 16; k++)
			unload(2'h3, 0, 1'h1, 16'h0300 + 16'(k));
		unload(2'h3, 0, 1'h0, '0);
		$display("Test full fifo done");
		summarize();
	end
endmodule // tb_slave_fifo_sync_port
